// *** hdl/afs_top.sv ***
// Filter path select, overrange flags and serial output of the converter.
// Assumes clk_i is the master clock, filter results arrive on the same clock,
// and start_i and shift_clock_i come from outside and need synchronising.
`timescale 1ns/1ps
module afs_top
   import afs_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic start_i,
   input wire logic [FILT_W-1:0] filt_data_i,
   input wire logic mod_overrange_i,
   input wire logic input_step_i,
   input wire logic shift_clock_i,
   output logic shift_clock_o,
   output logic shift_clock_n_o,
   output logic shift_clock_oe_o,
   output logic serial_out_o,
   output logic serial_out_n_o,
   output logic conversion_ready_strobe_o,
   output logic conversion_ready_strobe_n_o,
   output logic analog_overrange_flag_o,
   output logic digital_overrange_flag_o,
   output logic pll_enable_o,
   output logic diff_swing_o,
   output logic wide_band_path_o
);
   afs_ser_if ser ();             // Link to the serializer.

   // Bus side state.
   logic [CTRL_W-1:0] ctrl_q;     // Settings written by software.
   logic [CTRL_W-1:0] cfg_q;      // Settings in force since the last start.
   logic [WORD_W-1:0] data_q;     // Last word handed to the serializer.
   logic [7:0] status;            // Live status bits.
   logic wr_fire;                 // Write takes effect this edge.
   logic [31:0] rd_d;             // Read data for the addressed register.

   // Conversion control.
   logic start_lvl;               // Filtered start pin level.
   logic start_prev_q;            // Start level one clock ago.
   logic start_req;               // Start from the pin or from software.
   logic running_q;               // Conversions are being made.
   logic [11:0] conv_cnt_q;       // Cycles left in this conversion.
   logic done;                    // Conversion finishes this cycle.
   logic hs;                      // High-speed rate in force.
   logic wb_path;                 // Wide-band filter path in force.
   logic diff;                    // Differential swings in force.
   logic ext_src;                 // External shift clock in use.

   // Clock multiplier model.
   logic locked_q;                // Multiplier has locked.
   logic [9:0] lock_cnt_q;        // Cycles spent locking.
   logic lock_pend_q;             // Next word marks lock completion.
   logic lock_word_q;             // Current word marks lock completion.

   // Result handling.
   logic [WORD_W-1:0] word_d;     // Clipped word.
   logic ovr_d;                   // Filter result beyond full scale.
   logic word_ovr_q;              // Overrange of the word being sent.
   logic strobe_prev_q;           // Serializer strobe one clock ago.
   logic ana_q;                   // Analog overrange flag.
   logic dig_q;                   // Digital overrange flag.
   logic [5:0] settle_q;          // Ready cycles left until settled.
   logic invalid_q;               // Rate changed during a conversion.

   // Shift clock generation and sampling.
   logic [2:0] div_q;             // Half-period countdown.
   logic sclk_q;                  // Internal shift clock.
   logic ext_lvl;                 // Filtered external shift clock.
   logic ext_prev_q;              // External clock one clock ago.

   afs_sync u_start_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .async_i(start_i),
      .level_o(start_lvl)
   );

   afs_sync u_sclk_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .async_i(shift_clock_i),
      .level_o(ext_lvl)
   );

   afs_serializer u_ser (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ser(ser)
   );

   // Decoded settings. The low-latency select overrides the path pin.
   assign hs = is_hs(cfg_q[2:0]);
   assign wb_path = cfg_q[F_LOWLAT] & cfg_q[F_FILTER_PATH_SEL];
   assign diff = hs | ~cfg_q[F_SWING];
   assign ext_src = ~diff & cfg_q[F_SCLK_SRC];

   // The bus answers one clock after the request and commits writes at the ack edge.
   assign wr_fire = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
   assign start_req = (start_lvl & ~start_prev_q)
                      | (wr_fire && wb_adr_i == ADR_CMD && wb_dat_i[F_START]);
   assign done = running_q & (locked_q | ~hs) & (conv_cnt_q == 12'h000);

   // Acknowledge each request once, unmapped ones too.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
         wb_dat_o <= rd_d;
      end
   end

   // Status snapshot for reads.
   always_comb begin
      status = 8'h00;
      status[S_ANA] = ana_q;
      status[S_DIG] = dig_q;
      status[S_SETTLED] = (settle_q == 6'h00);
      status[S_LOCKED] = locked_q;
      status[S_WB] = wb_path;
      status[S_HS] = hs;
      status[S_INVALID] = invalid_q;
      status[S_LOCKWORD] = lock_word_q;
   end

   // Read mux; unmapped addresses and the command register read as zero.
   always_comb begin
      case (wb_adr_i)
         ADR_CTRL: rd_d = {{(32 - CTRL_W){1'b0}}, ctrl_q};
         ADR_STATUS: rd_d = {24'h00_0000, status};
         ADR_DATA: rd_d = {8'h00, data_q};
         default: rd_d = 32'h0000_0000;
      endcase
   end

   // Software settings; they only act once a start latches them.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= CTRL_RESET;
      end else if (wr_fire && wb_adr_i == ADR_CTRL) begin
         ctrl_q <= wb_dat_i[CTRL_W-1:0];
      end
   end

   // Start latches the settings and restarts the conversion timer.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_q <= CTRL_RESET;
         running_q <= 1'b0;
         conv_cnt_q <= 12'h000;
         start_prev_q <= 1'b0;
      end else begin
         start_prev_q <= start_lvl;
         if (start_req) begin
            cfg_q <= ctrl_q;
            running_q <= 1'b1;
            conv_cnt_q <= rate_period(ctrl_q[2:0]) - 12'h001;
         end else if (done) begin
            conv_cnt_q <= rate_period(cfg_q[2:0]) - 12'h001;
         end else if (running_q && conv_cnt_q != 12'h000) begin
            conv_cnt_q <= conv_cnt_q - 12'h001;
         end
      end
   end

   // A rate written while a conversion runs spoils that conversion.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         invalid_q <= 1'b0;
      end else if (start_req) begin
         invalid_q <= 1'b0;
      end else if (wr_fire && wb_adr_i == ADR_CTRL && running_q
                   && wb_dat_i[2:0] != cfg_q[2:0]) begin
         invalid_q <= 1'b1;
      end
   end

   // Multiplier runs only at high speed; lock takes a fixed count.
   // Leaving high speed drops lock, so a return always relocks.
   always_ff @(posedge clk_i) begin
      if (rst_i || !hs) begin
         locked_q <= 1'b0;
         lock_cnt_q <= 10'h000;
         lock_pend_q <= 1'b0;
      end else if (!locked_q) begin
         if (lock_cnt_q == PLL_LOCK_CYC - 10'h001) begin
            locked_q <= 1'b1;
            lock_pend_q <= 1'b1;
         end else begin
            lock_cnt_q <= lock_cnt_q + 10'h001;
         end
      end else if (done) begin
         lock_pend_q <= 1'b0;
      end
   end

   // Marks the word that comes with the lock-complete ready pulse.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lock_word_q <= 1'b0;
      end else if (done) begin
         lock_word_q <= lock_pend_q & hs;
      end
   end

   // Clip to full scale; high speed keeps bit zero low.
   always_comb begin
      word_d = filt_data_i[WORD_W-1:0];
      ovr_d = 1'b0;
      if ($signed(filt_data_i) > $signed(POS_EXT)) begin
         word_d = POS_FULL;
         ovr_d = 1'b1;
      end else if ($signed(filt_data_i) < $signed(NEG_EXT)) begin
         word_d = NEG_FULL;
         ovr_d = 1'b1;
      end
      if (hs) begin
         word_d[0] = 1'b0;
      end
   end

   // Capture the finished word for readback and for the flag logic.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         data_q <= '0;
         word_ovr_q <= 1'b0;
      end else if (done) begin
         data_q <= word_d;
         word_ovr_q <= ovr_d;
      end
   end

   // Digital flag updates only at strobe rising edges, so it follows the
   // word being sent and falls on the first in-range word.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         strobe_prev_q <= 1'b0;
         dig_q <= 1'b0;
      end else begin
         strobe_prev_q <= ser.strobe;
         if (ser.strobe && !strobe_prev_q) begin
            dig_q <= word_ovr_q;
         end
      end
   end

   // Analog flag rises at once, but falls only with the strobe falling edge.
   // A new overrange in that same cycle keeps the flag up.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ana_q <= 1'b0;
      end else if (mod_overrange_i) begin
         ana_q <= 1'b1;
      end else if (!ser.strobe && strobe_prev_q) begin
         ana_q <= 1'b0;
      end
   end

   // Wide-band settling: a step without start costs 55 ready cycles.
   always_ff @(posedge clk_i) begin
      if (rst_i || start_req) begin
         settle_q <= 6'h00;
      end else if (input_step_i && wb_path && running_q) begin
         settle_q <= SETTLE_READY;
      end else if (done && settle_q != 6'h00) begin
         settle_q <= settle_q - 6'h01;
      end
   end

   // Internal shift clock restarts low at each load; fast at high speed.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_q <= 3'h0;
         sclk_q <= 1'b0;
      end else if (div_q == 3'h0 || ser.load) begin
         div_q <= (hs ? SCK_HALF_HS : SCK_HALF_LS) - 3'h1;
         sclk_q <= ~sclk_q & ~ser.load;
      end else begin
         div_q <= div_q - 3'h1;
      end
   end

   // Edge history of the external clock, read only after filtering.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ext_prev_q <= 1'b0;
      end else begin
         ext_prev_q <= ext_lvl;
      end
   end

   // Serializer feed: one word per conversion, shifted on falling edges.
   assign ser.load = done;
   assign ser.word = word_d;
   assign ser.strobe_len = hs ? STROBE_PER_HS : STROBE_PER_LS;
   assign ser.tick = ext_src ? (~ext_lvl & ext_prev_q)
                             : (div_q == 3'h0 && sclk_q);

   // Pin registers; complement pins follow their true pins.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         serial_out_o <= 1'b0;
         serial_out_n_o <= 1'b1;
         conversion_ready_strobe_o <= 1'b0;
         conversion_ready_strobe_n_o <= 1'b1;
         shift_clock_o <= 1'b0;
         shift_clock_n_o <= 1'b1;
         shift_clock_oe_o <= 1'b0;
      end else begin
         serial_out_o <= ser.sdata;
         serial_out_n_o <= ~ser.sdata;
         conversion_ready_strobe_o <= ser.strobe;
         conversion_ready_strobe_n_o <= ~ser.strobe;
         shift_clock_o <= sclk_q;
         shift_clock_n_o <= ~sclk_q;
         shift_clock_oe_o <= ~ext_src;
      end
   end

   // Flag and mode pins.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         analog_overrange_flag_o <= 1'b0;
         digital_overrange_flag_o <= 1'b0;
         pll_enable_o <= 1'b0;
         diff_swing_o <= 1'b0;
         wide_band_path_o <= 1'b0;
      end else begin
         analog_overrange_flag_o <= mod_overrange_i | ana_q & (ser.strobe | ~strobe_prev_q);
         digital_overrange_flag_o <= dig_q;
         pll_enable_o <= hs;
         diff_swing_o <= diff;
         wide_band_path_o <= wb_path;
      end
   end
endmodule // afs_top

// *** hdl/afs_pkg.sv ***
// Constants, field layouts and decode functions of the converter output block.
// Assumes a single 25 MHz system clock; imported by afs_top and afs_serializer.
// Notes on behaviour
// - Wide-band path: rate_select picks one data rate.
// - lowlat_config_sel low forces low-latency path.
// - Wide band: unsettled for 55 ready cycles.
// - Analog flag follows modulator overrange, clock synchronous.
// - Analog flag falls with ready strobe falling.
// - Digital flag rises at ready rising edge.
// - Digital flag falls at next ready rising edge.
// - Low-speed codes allow CMOS or differential swings.
// - High-speed codes force differential output.
// - CMOS: shift clock internal or external, selectable.
// - Clock multiplier enabled only in high-speed modes.
// - High speed: continuous fast shift clock.
// - High speed: ready lasts three shift periods.
// - High speed: 24 bits shifted per conversion.
// - Differential swing drives complementary pin pairs.
// - Serial word shifted most significant bit first.
// - Start sampled on rising master clock edge.
// - Low speed: 24-bit words clipped at full scale.
// - High speed: word bit zero held low.
package afs_pkg;
   localparam int CLK_PERIOD_NS = 40;             // System clock period at 25 MHz.
   localparam int WORD_W = 24;                    // Output word width.
   localparam int FILT_W = 26;                    // Filter result width, two guard bits.
   localparam int CTRL_W = 7;                     // Width of the control register.
   // Register byte offsets on the bus.
   localparam logic [7:0] ADR_CTRL = 8'h00;
   localparam logic [7:0] ADR_CMD = 8'h04;
   localparam logic [7:0] ADR_STATUS = 8'h08;
   localparam logic [7:0] ADR_DATA = 8'h0c;
   // Control register fields.
   localparam int F_LOWLAT = 3;
   localparam int F_FILTER_PATH_SEL = 4;
   localparam int F_SWING = 5;                    // One selects CMOS swings.
   localparam int F_SCLK_SRC = 6;                 // One selects the external shift clock.
   localparam int F_START = 0;                    // Command register start bit.
   localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h18;
   // Status register bit positions.
   localparam int S_ANA = 0;
   localparam int S_DIG = 1;
   localparam int S_SETTLED = 2;
   localparam int S_LOCKED = 3;
   localparam int S_WB = 4;
   localparam int S_HS = 5;
   localparam int S_INVALID = 6;
   localparam int S_LOCKWORD = 7;
   // Full-scale codes, in word width and in filter width.
   localparam logic [WORD_W-1:0] POS_FULL = 24'h7f_ffff;
   localparam logic [WORD_W-1:0] NEG_FULL = 24'h80_0000;
   localparam logic [FILT_W-1:0] POS_EXT = 26'h7f_ffff;
   localparam logic [FILT_W-1:0] NEG_EXT = 26'h380_0000;
   // Timing counts: settling in ready cycles, strobe widths in shift periods, lock and half periods in system clock cycles; then the high-speed rate codes.
   localparam logic [5:0] SETTLE_READY = 6'h37;
   localparam logic [9:0] PLL_LOCK_CYC = 10'h100;
   localparam logic [2:0] SCK_HALF_LS = 3'h4;
   localparam logic [2:0] SCK_HALF_HS = 3'h1;
   localparam logic [1:0] STROBE_PER_HS = 2'h3;
   localparam logic [1:0] STROBE_PER_LS = 2'h1;
   localparam logic [2:0] RATE_HS0 = 3'h4;
   localparam logic [2:0] RATE_HS1 = 3'h5;

   // True for the two high-speed rate codes.
   function automatic logic is_hs(input logic [2:0] r);
      return (r == RATE_HS0) || (r == RATE_HS1);
   endfunction

   // Clock cycles per conversion for each rate code; spare codes run slowest.
   function automatic logic [11:0] rate_period(input logic [2:0] r);
      case (r)
         3'h1: return 12'h400;
         3'h2: return 12'h200;
         3'h3: return 12'h100;
         3'h4: return 12'h040;
         3'h5: return 12'h080;
         default: return 12'h800;
      endcase
   endfunction
endpackage

// *** hdl/afs_ser_if.sv ***
// Interface between the control logic and the serializer.
// Assumes both ends share the system clock; it carries no clock itself.
`timescale 1ns/1ps
interface afs_ser_if;
   logic load;                   // One-cycle pulse: a new word is ready.
   logic [23:0] word;            // Word to send, valid with load.
   logic tick;                   // Falling shift clock edge, one-cycle pulse.
   logic [1:0] strobe_len;       // Ready width in shift clock periods.
   logic strobe;                 // Ready strobe level from the serializer.
   logic sdata;                  // Serial data bit from the serializer.
   modport ctl (output load, word, tick, strobe_len, input strobe, sdata);
   modport ser (input load, word, tick, strobe_len, output strobe, sdata);
endinterface

// *** hdl/afs_sync.sv ***
// Three-stage synchroniser with agreement filter for one asynchronous input.
// Assumes the input may change at any time relative to clk_i.
`timescale 1ns/1ps
module afs_sync (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic async_i,
   output logic level_o
);
   logic [2:0] stg_q; // Stage zero feeds only stage one.

   // Shift the pin through the three stages.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stg_q <= 3'h0;
      end else begin
         stg_q <= {stg_q[1:0], async_i};
      end
   end

   // A change counts only once stages one and two agree.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         level_o <= 1'b0;
      end else if (stg_q[1] == stg_q[2]) begin
         level_o <= stg_q[2];
      end
   end
endmodule // afs_sync

// *** hdl/afs_serializer.sv ***
// Serializer: ready strobe followed by the word, one bit per shift clock.
// Assumes tick marks falling shift clock edges and load arrives once per word.
`timescale 1ns/1ps
module afs_serializer
   import afs_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   afs_ser_if.ser ser
);
   logic [WORD_W-1:0] sr_q;   // Bits still to send, next one on top.
   logic [1:0] stb_cnt_q;     // Shift periods left in the ready strobe.
   logic [4:0] left_q;        // Data bits left after the current one.
   logic strobe_q;            // Ready strobe level.
   logic sdata_q;             // Bit on the data line.

   // A load restarts the frame, so a late word never mixes with a new one.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sr_q <= '0;
         stb_cnt_q <= 2'h0;
         left_q <= 5'h0;
         strobe_q <= 1'b0;
         sdata_q <= 1'b0;
      end else if (ser.load) begin
         sr_q <= ser.word;
         stb_cnt_q <= ser.strobe_len;
         left_q <= 5'h0;
         strobe_q <= 1'b1;
         sdata_q <= 1'b0;
      end else if (ser.tick) begin
         if (strobe_q) begin
            // Strobe width is counted in shift clock periods.
            if (stb_cnt_q <= 2'h1) begin
               strobe_q <= 1'b0;
               sdata_q <= sr_q[WORD_W-1];
               sr_q <= {sr_q[WORD_W-2:0], 1'b0};
               left_q <= 5'(WORD_W - 1);
            end else begin
               stb_cnt_q <= stb_cnt_q - 2'h1;
            end
         end else if (left_q != 5'h0) begin
            sdata_q <= sr_q[WORD_W-1];
            sr_q <= {sr_q[WORD_W-2:0], 1'b0};
            left_q <= left_q - 5'h1;
         end else begin
            sdata_q <= 1'b0;
         end
      end
   end

   assign ser.strobe = strobe_q;
   assign ser.sdata = sdata_q;
endmodule // afs_serializer

// *** verification/afs_top_monitor.sv ***
// Port checks of the converter output block.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
module afs_top_monitor (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic mod_overrange_i,
   input wire logic shift_clock_oe_o,
   input wire logic serial_out_o,
   input wire logic serial_out_n_o,
   input wire logic conversion_ready_strobe_o,
   input wire logic analog_overrange_flag_o,
   input wire logic digital_overrange_flag_o,
   input wire logic pll_enable_o,
   input wire logic diff_swing_o
);
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // Fast strobe: three shift periods of two clocks each.
   sequence s_hs_pulse;
      conversion_ready_strobe_o [*6] ##1 !conversion_ready_strobe_o;
   endsequence
   // Slow strobe on the internal clock: one shift period of eight clocks.
   sequence s_ls_pulse;
      conversion_ready_strobe_o [*8] ##1 !conversion_ready_strobe_o;
   endsequence
   property p_ack_next;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
   endproperty
   a_ack_next: assert property (p_ack_next) else $error("bus ack late");
   property p_ack_one;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_one: assert property (p_ack_one) else $error("bus ack too long");
   property p_sdo_pair;
      serial_out_n_o == !serial_out_o;
   endproperty
   a_sdo_pair: assert property (p_sdo_pair) else $error("data pair broken");
   property p_hs_diff;
      pll_enable_o |-> diff_swing_o;
   endproperty
   a_hs_diff: assert property (p_hs_diff) else $error("fast not diff");
   property p_oe_cmos;
      !shift_clock_oe_o |-> !diff_swing_o;
   endproperty
   a_oe_cmos: assert property (p_oe_cmos) else $error("clock pin released");
   property p_hs_width;
      pll_enable_o && $rose(conversion_ready_strobe_o) |-> s_hs_pulse;
   endproperty
   a_hs_width: assert property (p_hs_width) else $error("fast strobe width");
   property p_ls_width;
      shift_clock_oe_o && !pll_enable_o && $rose(conversion_ready_strobe_o) |-> s_ls_pulse;
   endproperty
   a_ls_width: assert property (p_ls_width) else $error("slow strobe width");
   property p_ana_rise;
      $rose(mod_overrange_i) |-> ##[1:3] analog_overrange_flag_o;
   endproperty
   a_ana_rise: assert property (p_ana_rise) else $error("analog flag late");
   property p_ana_fall;
      $fell(analog_overrange_flag_o) |-> !conversion_ready_strobe_o && $past(conversion_ready_strobe_o);
   endproperty
   a_ana_fall: assert property (p_ana_fall) else $error("analog flag fall");
   property p_dig_edge;
      $changed(digital_overrange_flag_o) |-> conversion_ready_strobe_o && !$past(conversion_ready_strobe_o, 2);
   endproperty
   a_dig_edge: assert property (p_dig_edge) else $error("digital flag edge");
endmodule // afs_top_monitor
bind afs_top afs_top_monitor i_afs_top_monitor (.*);

// *** verification/afs_host_model.sv ***
// Host reader: collects one word after each ready strobe.
// Assumes data changes on the edge opposite to the one sampled here.
`timescale 1ns/1ps
module afs_host_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic sclk_i,
   input wire logic sdata_i,
   input wire logic ready_i,
   output logic [23:0] word_o,
   output logic valid_o
);
   logic sclk_q; // Last clock level, to find its edge.
   logic rdy_q; // Last strobe level, to find its fall.
   logic [4:0] left_q; // Bits still to take.
   // Reading starts only after the strobe ends, one word per strobe.
   always_ff @(posedge clk_i) begin
      sclk_q <= sclk_i;
      rdy_q <= ready_i;
      valid_o <= 1'b0;
      if (rst_i) begin
         left_q <= 5'h00;
      end else if (rdy_q && !ready_i) begin
         left_q <= 5'h18;
      end else if (left_q != 5'h00 && sclk_i && !sclk_q) begin
         word_o <= {word_o[22:0], sdata_i}; // First bit ends on top.
         left_q <= left_q - 5'h01;
         valid_o <= (left_q == 5'h01);
      end
   end
endmodule // afs_host_model

// *** verification/afs_top_tb_top.sv ***
// Bench for the converter output block: bus, start pin, filter data, host.
// Assumes the host model returns each shifted word in parallel.
`timescale 1ns/1ps
module afs_top_tb_top;
   import afs_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h0000_0000;
   logic [3:0] wb_sel_i = 4'h0;
   logic wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, start_i = 1'b0, hs = 1'b0, ext_q = 1'b0;
   logic mod_overrange_i = 1'b0, input_step_i = 1'b0, shift_clock_i = 1'b0;
   logic [FILT_W-1:0] filt_data_i = 26'h000_0000;
   logic [31:0] wb_dat_o, rd, rnd = 32'h9470_8e5f;
   logic wb_ack_o, shift_clock_o, shift_clock_n_o, shift_clock_oe_o, serial_out_o, serial_out_n_o;
   logic conversion_ready_strobe_o, conversion_ready_strobe_n_o, analog_overrange_flag_o;
   logic digital_overrange_flag_o, pll_enable_o, diff_swing_o, wide_band_path_o, word_ok;
   logic [23:0] word;
   logic [23:0] exp_q[$]; // Expected words, oldest first.
   int error_cnt = 0, num_checks = 0;
   // Per rate code: {pll, diff, wide band, clock pin driven} then control word.
   logic [11:0] modes [6] = '{12'h718, 12'h339, 12'h27a, 12'h513, 12'hf1c, 12'hf3d};
   afs_top i_afs_top (.*);
   afs_host_model i_afs_host_model (.clk_i, .rst_i, .sclk_i(ext_q ? ~shift_clock_i : shift_clock_o),
      .sdata_i(serial_out_o), .ready_i(conversion_ready_strobe_o), .word_o(word), .valid_o(word_ok));
   // Master clock; the link clock runs only in the external-clock mode.
   initial forever #20 clk_i = ~clk_i;
   initial begin
      #7;
      forever #160 shift_clock_i = ext_q ? ~shift_clock_i : 1'b0;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // One classic bus cycle, held until ack is sampled.
   task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      wb_adr_i <= a;
      wb_we_i <= w;
      wb_dat_i <= d;
      wb_sel_i <= 4'hf;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      r = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   // Sets filter data, skips the word in flight, then expects one word of it.
   task automatic conv(input logic [25:0] v, input logic [23:0] e, input logic d);
      int n;
      n = 0;
      filt_data_i <= v;
      do begin
         @(posedge clk_i);
         n++;
      end while (word_ok !== 1'b1 && n < 5000); // Lock word falls here too.
      @(posedge clk_i);
      exp_q.push_back(hs ? {e[23:1], 1'b0} : e);
      while (exp_q.size() != 0 && n < 10000) begin
         @(posedge clk_i);
         n++;
      end
      check("wait", {31'h0, n < 10000}, 32'h1);
      check("dflag", {31'h0, digital_overrange_flag_o}, {31'h0, d});
   endtask
   task automatic give_verdict;
      $display("Checks %0d, errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Compares each collected word with the oldest note.
   always @(posedge clk_i) begin
      if (word_ok === 1'b1 && exp_q.size() != 0) begin
         check("word", {8'h0, word}, {8'h0, exp_q.pop_front()});
      end
   end
   initial begin
      repeat (90000) @(posedge clk_i);
      error_cnt++;
      give_verdict();
   end
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wb(ADR_CTRL, 1'b0, 32'h0, rd);
      check("ctrl", rd, {25'h0, CTRL_RESET});
      wb(8'h10, 1'b0, 32'h0, rd);
      check("hole", rd, 32'h0);
      for (int m = 0; m < 6; m++) begin
         wb(ADR_CTRL, 1'b1, {25'h0, modes[m][6:0]}, rd);
         ext_q <= modes[m][6];
         hs = modes[m][11];
         // A start follows every control change, by command or by pin.
         if (m % 2 == 1) begin
            wb(ADR_CMD, 1'b1, 32'h1, rd);
         end else begin
            start_i <= 1'b1;
            repeat (6) @(posedge clk_i);
            start_i <= 1'b0;
         end
         repeat (8) @(posedge clk_i);
         check("mode", {28'h0, pll_enable_o, diff_swing_o, wide_band_path_o, shift_clock_oe_o},
            {28'h0, modes[m][11:8]});
         rnd = lfsr(rnd);
         conv({{2{rnd[23]}}, rnd[23:0]}, rnd[23:0], 1'b0);
         conv(26'h100_0000, POS_FULL, 1'b1);
         conv(26'h2ff_ffff, NEG_FULL, 1'b1);
      end
      input_step_i <= 1'b1;
      @(posedge clk_i);
      input_step_i <= 1'b0;
      repeat (53 * 128) @(posedge clk_i);
      wb(ADR_STATUS, 1'b0, 32'h0, rd);
      check("settle", {31'h0, rd[S_SETTLED]}, 32'h0);
      repeat (4 * 128) @(posedge clk_i);
      wb(ADR_STATUS, 1'b0, 32'h0, rd);
      check("settle", {31'h0, rd[S_SETTLED]}, 32'h1);
      mod_overrange_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      check("aflag", {31'h0, analog_overrange_flag_o}, 32'h1);
      mod_overrange_i <= 1'b0;
      repeat (300) @(posedge clk_i);
      check("aflag", {31'h0, analog_overrange_flag_o}, 32'h0);
      give_verdict();
   end
endmodule // afs_top_tb_top
